// [dv/p1rst_board.sv]
// Board model: resolves the port pins and holds the reset button.
`default_nettype none
module p1rst_board
(
  input  wire logic       CLK_SYS,
  input  wire logic       PORT_ONE_PIN_ZERO_O,
  input  wire logic       PORT_ONE_PIN_ZERO_OE,
  input  wire logic       PORT_ONE_PIN_ZERO_PU,
  input  wire logic       PORT_ONE_PIN_ONE_O,
  input  wire logic       PORT_ONE_PIN_ONE_OE,
  input  wire logic       PORT_ONE_PIN_ONE_PU,
  input  wire logic [1:0] peer_en,
  input  wire logic [1:0] peer_val,
  input  wire logic       button_low,
  output logic            PORT_ONE_PIN_ZERO_I,
  output logic            PORT_ONE_PIN_ONE_I,
  output logic            PORT_ONE_PIN_FIVE_INPUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_q = 1'b0;
  // A floating pin toggles, so no check can lean on a stale level.
  always @(posedge CLK_SYS) float_q <= ~float_q;
  // Device drive wins, then the peer, then the weak pull-up.
  assign PORT_ONE_PIN_ZERO_I = PORT_ONE_PIN_ZERO_OE ? PORT_ONE_PIN_ZERO_O :
    peer_en[0] ? peer_val[0] : (PORT_ONE_PIN_ZERO_PU | float_q);
  assign PORT_ONE_PIN_ONE_I = PORT_ONE_PIN_ONE_OE ? PORT_ONE_PIN_ONE_O :
    peer_en[1] ? peer_val[1] : (PORT_ONE_PIN_ONE_PU | float_q);
  // Pin five has a board pull-up; only the button pulls it low.
  assign PORT_ONE_PIN_FIVE_INPUT = ~button_low;
endmodule
`default_nettype wire

// [dv/test_p1rst_port.sv]
// Self-checking bench for the port one pin block.
`default_nettype none
module test_p1rst_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSES = 2;
  logic CLK_SYS, RESET_N, TXD_EN, TXD_DATA, RXD_EN, POR_ACTIVE;
  logic USER_CONFIG_BYTE_ONE_RST_EN, button_low;
  logic PORT_ONE_PIN_ZERO_I, PORT_ONE_PIN_ONE_I, PORT_ONE_PIN_FIVE_INPUT;
  logic PORT_ONE_PIN_ZERO_O, PORT_ONE_PIN_ZERO_OE, PORT_ONE_PIN_ZERO_PU;
  logic PORT_ONE_PIN_ONE_O, PORT_ONE_PIN_ONE_OE, PORT_ONE_PIN_ONE_PU;
  logic [1:0] LATCH_WR, LATCH_WDATA, MODE_WR, peer_en, peer_val;
  logic [3:0] MODE_WDATA;
  logic [2:0] PORT_RD_DATA, drv0, drv1;
  logic RXD_DATA, DEVICE_RESET_N, CORE_START, ISP_ENTRY;
  logic [15:0] FETCH_ADDR;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  assign drv0 = {PORT_ONE_PIN_ZERO_OE, PORT_ONE_PIN_ZERO_O,
                 PORT_ONE_PIN_ZERO_PU};
  assign drv1 = {PORT_ONE_PIN_ONE_OE, PORT_ONE_PIN_ONE_O,
                 PORT_ONE_PIN_ONE_PU};
  p1rst_port #(.ISP_PULSES(PULSES)) dut (.CLK_SYS, .RESET_N,
    .PORT_ONE_PIN_ZERO_I, .PORT_ONE_PIN_ZERO_O, .PORT_ONE_PIN_ZERO_OE,
    .PORT_ONE_PIN_ZERO_PU, .PORT_ONE_PIN_ONE_I, .PORT_ONE_PIN_ONE_O,
    .PORT_ONE_PIN_ONE_OE, .PORT_ONE_PIN_ONE_PU, .PORT_ONE_PIN_FIVE_INPUT,
    .LATCH_WR, .LATCH_WDATA, .MODE_WR, .MODE_WDATA, .PORT_RD_DATA,
    .TXD_EN, .TXD_DATA, .RXD_EN, .RXD_DATA, .USER_CONFIG_BYTE_ONE_RST_EN,
    .POR_ACTIVE, .DEVICE_RESET_N, .CORE_START, .FETCH_ADDR, .ISP_ENTRY);
  p1rst_board board (.CLK_SYS, .PORT_ONE_PIN_ZERO_O, .PORT_ONE_PIN_ZERO_OE,
    .PORT_ONE_PIN_ZERO_PU, .PORT_ONE_PIN_ONE_O, .PORT_ONE_PIN_ONE_OE,
    .PORT_ONE_PIN_ONE_PU, .peer_en, .peer_val, .button_low,
    .PORT_ONE_PIN_ZERO_I, .PORT_ONE_PIN_ONE_I, .PORT_ONE_PIN_FIVE_INPUT);
  // ------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ------------------------------------------------------------------
  // The 4 ns system clock.
  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  // The whole run needs well under 1000 cycles, so 3000 means a hang.
  always @(posedge CLK_SYS)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  // One write strobe for mode and latch together; outputs settle after.
  task automatic cfg(logic [1:0] pin, logic [3:0] mode, logic [1:0] lat);
    MODE_WR = pin;
    MODE_WDATA = mode;
    LATCH_WR = pin;
    LATCH_WDATA = lat;
    cyc(1);
    MODE_WR = 2'b00;
    LATCH_WR = 2'b00;
    cyc(3);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Power-on with n pulses on pin five; programming entry expected or not.
  task automatic isp_run(int n, logic exp);
    RESET_N = 1'b0;
    POR_ACTIVE = 1'b1;
    cyc(6);
    chk("drv_rst", 6'h00, {drv0, drv1});
    chk("rxd_rst", 1'b1, RXD_DATA);
    RESET_N = 1'b1;
    cyc(6);
    chk("run", 1'b1, DEVICE_RESET_N);
    chk("vector", 16'h0000, FETCH_ADDR);
    repeat (n)
    begin
      button_low = 1'b1;
      cyc(4);
      chk("por_rst", 1'b0, DEVICE_RESET_N);
      button_low = 1'b0;
      cyc(4);
    end
    POR_ACTIVE = 1'b0;
    cyc(3);
    chk("isp", exp, ISP_ENTRY);
  endtask
  // Every mode with both latch values on pin zero, then pin one alone.
  task automatic mode_run();
    logic [2:0] exp0 [8] = '{3'h5, 3'h4, 3'h0, 3'h4,
                             3'h1, 3'h6, 3'h0, 3'h0};
    for (int i = 0; i < 8; i++)
    begin
      cfg(2'b01, 4'(i % 4), 2'(i / 4));
      chk("drv0", 16'(exp0[i]), drv0);
      chk("drv1", 3'h0, drv1);
    end
    // The peer holds undriven pin zero low, so the read never floats.
    peer_en = 2'b01;
    cfg(2'b10, 4'h4, 2'b10);
    chk("drv1", 3'h6, drv1);
    chk("drv0", 3'h0, drv0);
    cyc(2);
    chk("read", 3'h6, PORT_RD_DATA);
    peer_en = 2'b00;
  endtask
  // Transmit overrides the latch on pin zero; pin one feeds the receiver.
  task automatic serial_run();
    cfg(2'b11, 4'h9, 2'b00);
    TXD_EN = 1'b1;
    TXD_DATA = 1'b1;
    cyc(4);
    chk("txd_hi", 3'h6, drv0);
    chk("rd0", 1'b1, PORT_RD_DATA[0]);
    TXD_DATA = 1'b0;
    cyc(4);
    chk("txd_lo", 3'h4, drv0);
    TXD_EN = 1'b0;
    peer_en = 2'b10;
    RXD_EN = 1'b1;
    cyc(4);
    chk("rxd_lo", 1'b0, RXD_DATA);
    peer_val = 2'b10;
    cyc(4);
    chk("rxd_hi", 1'b1, RXD_DATA);
    peer_val = 2'b00;
    RXD_EN = 1'b0;
    cyc(4);
    chk("rxd_off", 1'b1, RXD_DATA);
    peer_en = 2'b00;
  endtask
  // Pin reset with the function on, writes refused, then function off.
  task automatic pin_reset_run();
    int starts;
    starts = 0;
    cfg(2'b01, 4'h1, 2'b01);
    USER_CONFIG_BYTE_ONE_RST_EN = 1'b1;
    button_low = 1'b1;
    cyc(4);
    chk("pin_rst", 1'b0, DEVICE_RESET_N);
    cfg(2'b01, 4'h1, 2'b01);
    chk("drv0_rst", 3'h0, drv0);
    button_low = 1'b0;
    repeat (8)
    begin
      cyc(1);
      starts += int'(CORE_START === 1'b1);
    end
    chk("starts", 16'h0001, 16'(starts));
    chk("drv0_rel", 3'h0, drv0);
    USER_CONFIG_BYTE_ONE_RST_EN = 1'b0;
    button_low = 1'b1;
    cyc(4);
    chk("no_rst", 1'b1, DEVICE_RESET_N);
    chk("rd5", 1'b0, PORT_RD_DATA[2]);
    button_low = 1'b0;
  endtask
  // Main sequence.
  initial
  begin
    {LATCH_WR, LATCH_WDATA, MODE_WR, MODE_WDATA} = '0;
    {TXD_EN, TXD_DATA, RXD_EN, USER_CONFIG_BYTE_ONE_RST_EN} = '0;
    {peer_en, peer_val, button_low} = '0;
    isp_run(PULSES, 1'b1);
    isp_run(1, 1'b0);
    mode_run();
    serial_run();
    pin_reset_run();
    final_report();
  end
endmodule
`default_nettype wire

// [rtl/p1rst_pkg.sv]
// Types shared by the port one pin block.
`default_nettype none
package p1rst_pkg;
  // Output driver type of one configurable pin.
  typedef enum logic [1:0]
  {
    P1RST_QUASI      = 2'b00,
    P1RST_PUSH_PULL  = 2'b01,
    P1RST_INPUT_ONLY = 2'b10,
    P1RST_OPEN_DRAIN = 2'b11
  } p1rst_mode_type;
endpackage
`default_nettype wire

// [rtl/p1rst_port.sv]
// Port one with serial alternate functions and shared reset input pin.
`default_nettype none
`include "p1rst_regs.svh"
module p1rst_port
#(
  parameter int ISP_PULSES = `P1RST_ISP_PULSES
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        PORT_ONE_PIN_ZERO_I,
  output logic             PORT_ONE_PIN_ZERO_O,
  output logic             PORT_ONE_PIN_ZERO_OE,
  output logic             PORT_ONE_PIN_ZERO_PU,
  input  wire logic        PORT_ONE_PIN_ONE_I,
  output logic             PORT_ONE_PIN_ONE_O,
  output logic             PORT_ONE_PIN_ONE_OE,
  output logic             PORT_ONE_PIN_ONE_PU,
  input  wire logic        PORT_ONE_PIN_FIVE_INPUT,
  input  wire logic [1:0]  LATCH_WR,
  input  wire logic [1:0]  LATCH_WDATA,
  input  wire logic [1:0]  MODE_WR,
  input  wire logic [3:0]  MODE_WDATA,
  output logic [2:0]       PORT_RD_DATA,
  input  wire logic        TXD_EN,
  input  wire logic        TXD_DATA,
  input  wire logic        RXD_EN,
  output logic             RXD_DATA,
  input  wire logic        USER_CONFIG_BYTE_ONE_RST_EN,
  input  wire logic        POR_ACTIVE,
  output logic             DEVICE_RESET_N,
  output logic             CORE_START,
  output logic [15:0]      FETCH_ADDR,
  output logic             ISP_ENTRY
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  // The pulse counter is three bits wide and saturates at seven.
  if (ISP_PULSES < 1 || ISP_PULSES > 6)
  begin : g_bad_pulses
    $error("ISP_PULSES must lie between 1 and 6.");
  end
  localparam logic [2:0] ISP_CNT = 3'(ISP_PULSES);

  // ----------------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] meta_q;
  logic [2:0] pin_s_q;
  logic [2:0] meta_d;
  logic [2:0] pin_s_d;
  assign pin_raw = {PORT_ONE_PIN_FIVE_INPUT, PORT_ONE_PIN_ONE_I,
                    PORT_ONE_PIN_ZERO_I};
  // Two flops per pin; only pin_s_q is read by any logic.
  always_comb
  begin
    meta_d  = pin_raw;
    pin_s_d = meta_q;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      meta_q  <= 3'h7;
      pin_s_q <= 3'h7;
    end
    else
    begin
      meta_q  <= meta_d;
      pin_s_q <= pin_s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Reset input function, reset request, start and programming entry
  // ----------------------------------------------------------------------
  logic       por_q,     por_d;
  logic       rst_n_q,   rst_n_d;
  logic       start_q,   start_d;
  logic       pin5_prev_q, pin5_prev_d;
  logic [2:0] isp_cnt_q, isp_cnt_d;
  logic       isp_q,     isp_d;
  logic       rst_func;
  logic       pin_rst;
  logic [15:0] fetch_q,  fetch_d;
  // The pin only resets while its function is on: always during power-on,
  // afterwards only when the configuration bit selects it.
  assign rst_func = por_q | USER_CONFIG_BYTE_ONE_RST_EN;
  assign pin_rst  = rst_func & ~pin_s_q[2];

  always_comb
  begin
    por_d       = POR_ACTIVE;
    rst_n_d     = ~pin_rst;
    start_d     = rst_n_d & ~rst_n_q;
    pin5_prev_d = pin_s_q[2];
    isp_cnt_d   = isp_cnt_q;
    isp_d       = isp_q;
    fetch_d     = rst_n_q ? fetch_q : `P1RST_RESET_VECTOR;
    // Falling edges of the reset pin are counted only during power-on.
    if (por_q && pin5_prev_q && !pin_s_q[2] && isp_cnt_q != 3'h7)
    begin
      isp_cnt_d = isp_cnt_q + 3'h1;
    end
    // The pattern is judged once, as the power-on sequence ends.
    if (por_q && !POR_ACTIVE && isp_cnt_q == ISP_CNT)
    begin
      isp_d = 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      por_q       <= 1'b1;
      rst_n_q     <= 1'b0;
      start_q     <= 1'b0;
      pin5_prev_q <= 1'b1;
      isp_cnt_q   <= 3'h0;
      isp_q       <= 1'b0;
      fetch_q     <= `P1RST_RESET_VECTOR;
    end
    else
    begin
      por_q       <= por_d;
      rst_n_q     <= rst_n_d;
      start_q     <= start_d;
      pin5_prev_q <= pin5_prev_d;
      isp_cnt_q   <= isp_cnt_d;
      isp_q       <= isp_d;
      fetch_q     <= fetch_d;
    end
  end
  assign DEVICE_RESET_N = rst_n_q;
  assign CORE_START     = start_q;
  assign ISP_ENTRY      = isp_q;
  // The fetch address reloads the reset vector while the device is held.
  assign FETCH_ADDR     = fetch_q;

  // ----------------------------------------------------------------------
  // Latches, modes and pin drivers of the two configurable pins
  // ----------------------------------------------------------------------
  p1rst_pkg::p1rst_mode_type mode_q [2];
  p1rst_pkg::p1rst_mode_type mode_d [2];
  logic [1:0] latch_q, latch_d;
  logic [1:0] alt_en;
  logic [1:0] alt_val;
  logic [1:0] drv_o_q, drv_o_d;
  logic [1:0] drv_oe_q, drv_oe_d;
  logic [1:0] pu_q, pu_d;
  logic [2:0] rd_q, rd_d;
  logic       rxd_q, rxd_d;

  // Returns {output enable, output level, pull-up} for a mode and value.
  function automatic logic [2:0] drive(p1rst_pkg::p1rst_mode_type m,
                                       logic v);
    unique case (m)
      p1rst_pkg::P1RST_QUASI:      drive = {~v, 1'b0, 1'b1};
      p1rst_pkg::P1RST_PUSH_PULL:  drive = {1'b1, v, 1'b0};
      p1rst_pkg::P1RST_INPUT_ONLY: drive = 3'h0;
      p1rst_pkg::P1RST_OPEN_DRAIN: drive = {~v, 1'b0, 1'b0};
    endcase
  endfunction

  assign alt_en  = {1'b0, TXD_EN};
  assign alt_val = {1'b0, TXD_DATA};

  // Each pin has its own strobe and field, so writes never touch the other.
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    always_comb
    begin
      latch_d[i] = latch_q[i];
      mode_d[i]  = mode_q[i];
      if (pin_rst)
      begin
        latch_d[i] = `P1RST_LATCH_RST;
        mode_d[i]  = p1rst_pkg::P1RST_INPUT_ONLY;
      end
      else
      begin
        if (LATCH_WR[i])
        begin
          latch_d[i] = LATCH_WDATA[i];
        end
        if (MODE_WR[i])
        begin
          mode_d[i] =
            p1rst_pkg::p1rst_mode_type'(MODE_WDATA[2*i +: 2]);
        end
      end
      // On pin zero the transmit function replaces the latch value as drive source.
      {drv_oe_d[i], drv_o_d[i], pu_d[i]} =
        drive(mode_q[i], alt_en[i] ? alt_val[i] : latch_q[i]);
      if (pin_rst)
      begin
        {drv_oe_d[i], drv_o_d[i], pu_d[i]} = 3'h0;
      end
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
      if (!RESET_N)
      begin
        latch_q[i]  <= `P1RST_LATCH_RST;
        mode_q[i]   <= p1rst_pkg::P1RST_INPUT_ONLY;
        drv_o_q[i]  <= 1'b0;
        drv_oe_q[i] <= 1'b0;
        pu_q[i]     <= 1'b0;
      end
      else
      begin
        latch_q[i]  <= latch_d[i];
        mode_q[i]   <= mode_d[i];
        drv_o_q[i]  <= drv_o_d[i];
        drv_oe_q[i] <= drv_oe_d[i];
        pu_q[i]     <= pu_d[i];
      end
    end
  end

  // Reads always return pin levels; the receiver sees pin one when enabled.
  always_comb
  begin
    rd_d  = pin_s_q;
    rxd_d = RXD_EN ? pin_s_q[1] : 1'b1;
  end
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rd_q  <= 3'h7;
      rxd_q <= 1'b1;
    end
    else
    begin
      rd_q  <= rd_d;
      rxd_q <= rxd_d;
    end
  end

  // Pin five has no driver at all; only pins zero and one reach outputs.
  assign PORT_ONE_PIN_ZERO_O  = drv_o_q[0];
  assign PORT_ONE_PIN_ZERO_OE = drv_oe_q[0];
  assign PORT_ONE_PIN_ZERO_PU = pu_q[0];
  assign PORT_ONE_PIN_ONE_O   = drv_o_q[1];
  assign PORT_ONE_PIN_ONE_OE  = drv_oe_q[1];
  assign PORT_ONE_PIN_ONE_PU  = pu_q[1];
  assign PORT_RD_DATA         = rd_q;
  assign RXD_DATA             = rxd_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_RESET_INPUT_ONLY: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    pin_rst |=> (PORT_ONE_PIN_ZERO_OE == 1'b0
                 && PORT_ONE_PIN_ONE_OE == 1'b0
                 && PORT_ONE_PIN_ZERO_PU == 1'b0
                 && PORT_ONE_PIN_ONE_PU == 1'b0))
    else $error("Pin driven or pulled up during reset.");
  AST_MODE_INDEPENDENT: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    (MODE_WR == 2'b01 && !pin_rst) |=> mode_q[1] == $past(mode_q[1]))
    else $error("Pin zero mode write changed pin one.");
  AST_TX_ROUTE: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    (TXD_EN && !pin_rst && mode_q[0] == p1rst_pkg::P1RST_PUSH_PULL)
      |=> PORT_ONE_PIN_ZERO_O == $past(TXD_DATA))
    else $error("Transmit data not on pin zero.");
  AST_RX_ROUTE: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    RXD_EN |=> RXD_DATA == $past(pin_s_q[1]))
    else $error("Receiver not fed from pin one.");
  AST_RESET_FUNC_OFF: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    (!por_q && !USER_CONFIG_BYTE_ONE_RST_EN) |=> DEVICE_RESET_N)
    else $error("Reset taken with reset function off.");
  AST_PIN_RESET: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    (rst_func && !pin_s_q[2]) |=> !DEVICE_RESET_N && latch_q == 2'b11)
    else $error("Low reset pin did not reset the device.");
  // The start pulse rises on the same edge as the released reset line.
  AST_START_AT_ZERO: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    $rose(DEVICE_RESET_N) |-> CORE_START && FETCH_ADDR == 16'h0000
      ##1 !CORE_START)
    else $error("Start pulse or fetch address wrong at release.");
  AST_ISP_ENTRY: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    $rose(ISP_ENTRY) |-> $past(isp_cnt_q) == ISP_CNT && $past(por_q))
    else $error("Programming mode entered without the pattern.");

endmodule
`default_nettype wire

// [rtl/p1rst_regs.svh]
// Constants for the port one pin block with shared reset input.
`ifndef P1RST_REGS_SVH
`define P1RST_REGS_SVH

// ----------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------
`define P1RST_LATCH_RST     1'h1
`define P1RST_RESET_VECTOR  16'h0000
`define P1RST_ISP_PULSES    3
`define P1RST_MAX_OSC_NORST_MHZ 12

`endif
